// ### design/scl_pkg.sv
`default_nettype none
package scl_pkg;
	// Register byte offsets
	localparam logic [7:0] SCL_OFF_CTRL = 8'h00;
	localparam logic [7:0] SCL_OFF_SLOT = 8'h04;
	localparam logic [7:0] SCL_OFF_BIT = 8'h08;
	localparam logic [7:0] SCL_OFF_PD = 8'h0C;
	localparam logic [7:0] SCL_OFF_SYNC = 8'h10;
	localparam logic [7:0] SCL_OFF_BLANK = 8'h14;
	localparam logic [7:0] SCL_OFF_STAT = 8'h18;
	// Field positions
	localparam int SCL_SYNC_JDG_LO = 8;
	localparam int SCL_SYNC_FRST_LO = 16;
	localparam int SCL_PD_ON_LO = 16;
	localparam int SCL_STAT_CNT_LO = 8;
	localparam int SCL_STAT_WORD_LO = 16;
	// Timing
	localparam int SCL_CLK_MHZ = 250;
	localparam int SCL_BIT_NS = 8000;
	localparam int SCL_BIT_CYC = SCL_BIT_NS * SCL_CLK_MHZ / 1000;
	localparam int SCL_SLOT_NS = 50000;
	localparam int SCL_SLOT_CYC = SCL_SLOT_NS * SCL_CLK_MHZ / 1000;
	localparam int SCL_BLANK_FIX_NS = 500000;
	localparam int SCL_BLANK_FIX_CYC = SCL_BLANK_FIX_NS * SCL_CLK_MHZ / 1000;
	localparam int SCL_PD_DLY_NS = 2000;
	localparam int SCL_PD_DLY_CYC = SCL_PD_DLY_NS * SCL_CLK_MHZ / 1000;
	localparam int SCL_PD_ON_NS = 10000;
	localparam int SCL_PD_ON_CYC = SCL_PD_ON_NS * SCL_CLK_MHZ / 1000;
	localparam int SCL_FRST_NS = 4000;
	localparam int SCL_FRST_CYC = SCL_FRST_NS * SCL_CLK_MHZ / 1000;
	// Sample ticks run at half the clock
	localparam int SCL_JUDGE_NS = 1000;
	localparam int SCL_JUDGE_TCK = SCL_JUDGE_NS * SCL_CLK_MHZ / 2000;
	localparam int SCL_SMIN_NS = 500;
	localparam int SCL_SMIN_TCK = (SCL_SMIN_NS * SCL_CLK_MHZ + 1999) / 2000;
	localparam logic [31:0] SCL_CTRL_RST = 32'h0000_0001;
	// Message kinds
	localparam logic [2:0] SCL_K_ACCEL = 3'h0;
	localparam logic [2:0] SCL_K_BUSY = 3'h1;
	localparam logic [2:0] SCL_K_READY = 3'h2;
	localparam logic [2:0] SCL_K_UNLOCK = 3'h3;
	localparam logic [2:0] SCL_K_DEFECT = 3'h4;
	localparam logic [2:0] SCL_K_NIBBLE = 3'h5;
	localparam logic [2:0] SCL_K_ID = 3'h6;
	// Fixed data codes
	localparam logic signed [14:0] SCL_LIM10 = 15'sh01E0;
	localparam logic signed [14:0] SCL_LIM8 = 15'sh0078;
	localparam logic [9:0] SCL_BUSY10 = 10'h1E8;
	localparam logic [9:0] SCL_READY10 = 10'h1E7;
	localparam logic [9:0] SCL_UNLOCK10 = 10'h1E6;
	localparam logic [9:0] SCL_DEFECT10 = 10'h1F4;
	localparam logic [9:0] SCL_NIB10 = 10'h210;
	localparam logic [9:0] SCL_ID10 = 10'h20F;
	localparam logic [7:0] SCL_BUSY8 = 8'h7C;
	localparam logic [7:0] SCL_READY8 = 8'h7B;
	localparam logic [7:0] SCL_UNLOCK8 = 8'h7A;
	localparam logic [7:0] SCL_DEFECT8 = 8'h7D;
	localparam logic [7:0] SCL_NIB8 = 8'h84;
	localparam logic [7:0] SCL_ID8 = 8'h83;
	localparam logic [2:0] SCL_CRC_SEED = 3'h7;

	typedef struct packed {
		logic [3:0] idx;
		logic [2:0] kind;
		logic pd_en;
		logic sync_blank_select;
		logic crc_sel;
		logic word_length_select;
	} scl_cfg_t;

	typedef enum logic [1:0] {ST_IDLE, ST_JUDGE, ST_BLANK} scl_state_t;
endpackage
`default_nettype wire

// ### design/scl_link_tx.sv
// What this block does
// RQ1: Master raises supply briefly to signal sync.
// RQ2: Count comparator at half rate, judge later.
// RQ3: Valid sync flags, references time, starts timers.
// RQ4: Blank detector for fixed or frame-derived interval.
// RQ5: Hold sync filter reset after valid sync.
// RQ6: Failed pulse clears timers, rearms detector immediately.
// RQ7: Timers start at first high comparator sample.
// RQ8: Optional pulldown sink after delay, for duration.
// RQ9: Wait slot delay before sending response.
// RQ10: Manchester mid-bit step, zero rises, one falls.
// RQ11: Two start bits, 8/10-bit word, LSB first.
// RQ12: Select parity or three-bit checksum.
// RQ13: Parity makes count of ones even.
// RQ14: CRC x^3+x+1, seed 111, three zeros.
// RQ15: CRC matches reference vectors for 10-bit words.
// RQ16: Acceleration two's complement, clipped per width.
// RQ17: Fixed status codes for busy, ready, defect.
// RQ18: Init nibbles use negative block starting at -496.
// RQ19: Init IDs use lowest codes.
// RQ20: Payload rounded and clipped from 26-bit filter.
// RQ21: Bit period from clock; idle after frame.
// RQ22: Detection counter saturates, never wraps.
//
// The placing of the registers and the AXI4-Lite register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module scl_link_tx #(
	parameter int unsigned BLANK_FIX_CYC = scl_pkg::SCL_BLANK_FIX_CYC,
	parameter int unsigned SLOT_CYC_DEF = scl_pkg::SCL_SLOT_CYC,
	parameter int unsigned BIT_CYC_DEF = scl_pkg::SCL_BIT_CYC
) (
	// Clock, reset, enable
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic ce,
	// AXI4-Lite slave
	input wire logic [7:0] awaddr,
	input wire logic awvalid,
	output logic awready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	input wire logic wvalid,
	output logic wready,
	output logic [1:0] bresp,
	output logic bvalid,
	input wire logic bready,
	input wire logic [7:0] araddr,
	input wire logic arvalid,
	output logic arready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic rvalid,
	input wire logic rready,
	// Sensor side
	input wire logic sync_cmp,
	input wire logic [25:0] filt_data,
	// Link side
	output logic mod_sink,
	output logic sync_valid,
	output logic filter_reset,
	output logic tx_busy
);
	import scl_pkg::*;

	if (BIT_CYC_DEF < 2 || BIT_CYC_DEF > 65535 || BLANK_FIX_CYC > 16777215
			|| SLOT_CYC_DEF > 16777215) begin : g_bad_param
		$error("scl_link_tx: parameter out of range");
	end

	////////////////////////////////////////////////////////////////////////
	// Functions

	function automatic logic [31:0] merge(logic [31:0] old, logic [31:0] nw,
			logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) r[8*i +: 8] = nw[8*i +: 8];
		end
		return r;
	endfunction

	function automatic logic [4:0] frame_bits(logic long, logic crc);
		return 5'd2 + (long ? 5'd10 : 5'd8) + (crc ? 5'd3 : 5'd1);
	endfunction

	// Data LSB first, then three zeros; start bits excluded
	function automatic logic [2:0] crc3(logic [9:0] w, logic long);
		logic [2:0] c;
		logic [12:0] s;
		logic fb;
		c = SCL_CRC_SEED;
		s = {3'h0, long ? w : {2'h0, w[7:0]}};
		for (int i = 0; i < 13; i++) begin
			if (long || i < 11) begin
				// Divide the augmented message: the data bit enters at the low end
				fb = c[2];
				c = {c[1], c[0] ^ fb, s[i] ^ fb};
			end
		end
		return c;
	endfunction // see RQ14

	function automatic logic [9:0] make_word(logic [25:0] d, logic [2:0] kind,
			logic [3:0] idx, logic long);
		logic signed [14:0] r;
		logic signed [14:0] lim;
		logic [9:0] w;
		// Round at the bit just below the kept field
		if (long) r = 15'(signed'(d[25:12])) + 15'(d[11]);
		else r = 15'(signed'(d[25:14])) + 15'(d[13]); // see RQ20
		lim = long ? SCL_LIM10 : SCL_LIM8;
		if (r > lim) r = lim;
		else if (r < -lim) r = -lim; // see RQ16
		w = long ? r[9:0] : {2'h0, r[7:0]};
		unique case (kind)
			SCL_K_BUSY: w = long ? SCL_BUSY10 : {2'h0, SCL_BUSY8};
			SCL_K_READY: w = long ? SCL_READY10 : {2'h0, SCL_READY8};
			SCL_K_UNLOCK: w = long ? SCL_UNLOCK10 : {2'h0, SCL_UNLOCK8};
			SCL_K_DEFECT: w = long ? SCL_DEFECT10 : {2'h0, SCL_DEFECT8}; // see RQ17
			SCL_K_NIBBLE: w = long ? 10'(SCL_NIB10 + 10'(idx))
				: {2'h0, 8'(SCL_NIB8 + 8'(idx[1:0]))}; // see RQ18
			SCL_K_ID: w = long ? 10'(SCL_ID10 - 10'(idx))
				: {2'h0, 8'(SCL_ID8 - 8'(idx[1:0]))}; // see RQ19
			default: ;
		endcase
		return w;
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Registers

	scl_cfg_t cfg;
	logic [23:0] slot_dly;
	logic [15:0] bit_cyc;
	logic [15:0] pd_dly;
	logic [15:0] pd_on;
	logic [7:0] sync_min;
	logic [7:0] judge_dly;
	logic [15:0] frst_cyc;
	logic [23:0] blank_fix;
	logic [7:0] sync_cnt_total;
	logic [9:0] last_word;
	logic aw_held;
	logic w_held;
	logic [7:0] wr_addr;
	logic [31:0] wr_data;
	logic [3:0] wr_strb;
	logic do_wr;
	logic [31:0] rd_mux;
	logic rd_hit;
	logic wr_hit;
	logic [31:0] nw;
	scl_state_t st;

	assign awready = ce && !aw_held && !bvalid;
	assign wready = ce && !w_held && !bvalid;
	assign arready = ce && !rvalid;
	assign do_wr = ce && aw_held && w_held && !bvalid;

	always_comb begin
		wr_hit = 1'b1;
		unique case (wr_addr)
			SCL_OFF_CTRL, SCL_OFF_SLOT, SCL_OFF_BIT, SCL_OFF_PD,
			SCL_OFF_SYNC, SCL_OFF_BLANK: ;
			default: wr_hit = 1'b0;
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			wr_addr <= 8'h00;
			wr_data <= 32'h0000_0000;
			wr_strb <= 4'h0;
			bvalid <= 1'b0;
			bresp <= 2'h0;
		end else if (ce) begin
			if (awvalid && awready) begin
				aw_held <= 1'b1;
				wr_addr <= awaddr;
			end
			if (wvalid && wready) begin
				w_held <= 1'b1;
				wr_data <= wdata;
				wr_strb <= wstrb;
			end
			if (do_wr) begin
				aw_held <= 1'b0;
				w_held <= 1'b0;
				bvalid <= 1'b1;
				bresp <= wr_hit ? 2'h0 : 2'h2;
			end else if (bvalid && bready) begin
				bvalid <= 1'b0;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			cfg <= scl_cfg_t'(SCL_CTRL_RST[10:0]);
			slot_dly <= 24'(SLOT_CYC_DEF);
			bit_cyc <= 16'(BIT_CYC_DEF);
			pd_dly <= 16'(SCL_PD_DLY_CYC);
			pd_on <= 16'(SCL_PD_ON_CYC);
			sync_min <= 8'(SCL_SMIN_TCK);
			judge_dly <= 8'(SCL_JUDGE_TCK);
			frst_cyc <= 16'(SCL_FRST_CYC);
			blank_fix <= 24'(BLANK_FIX_CYC);
		end else if (do_wr) begin
			unique case (wr_addr)
				SCL_OFF_CTRL: cfg <= scl_cfg_t'(nw[10:0]);
				SCL_OFF_SLOT: slot_dly <= nw[23:0];
				// Odd or tiny periods would break the half-bit split
				SCL_OFF_BIT: bit_cyc <= (nw[15:0] < 16'h0002) ? 16'h0002
					: {nw[15:1], 1'b0}; // see RQ21
				SCL_OFF_PD: begin
					pd_dly <= nw[15:0];
					pd_on <= nw[SCL_PD_ON_LO +: 16];
				end
				SCL_OFF_SYNC: begin
					sync_min <= nw[7:0];
					judge_dly <= nw[SCL_SYNC_JDG_LO +: 8];
					frst_cyc <= nw[SCL_SYNC_FRST_LO +: 16];
				end
				SCL_OFF_BLANK: blank_fix <= nw[23:0];
				default: ;
			endcase
		end
	end

	always_comb begin
		rd_hit = 1'b1;
		rd_mux = 32'h0000_0000;
		unique case (araddr)
			SCL_OFF_CTRL: rd_mux = {21'h00_0000, cfg};
			SCL_OFF_SLOT: rd_mux = {8'h00, slot_dly};
			SCL_OFF_BIT: rd_mux = {16'h0000, bit_cyc};
			SCL_OFF_PD: rd_mux = {pd_on, pd_dly};
			SCL_OFF_SYNC: rd_mux = {frst_cyc, judge_dly, sync_min};
			SCL_OFF_BLANK: rd_mux = {8'h00, blank_fix};
			SCL_OFF_STAT: begin
				rd_mux[0] = tx_busy;
				rd_mux[1] = (st == ST_BLANK);
				rd_mux[2] = filter_reset;
				rd_mux[SCL_STAT_CNT_LO +: 8] = sync_cnt_total;
				rd_mux[SCL_STAT_WORD_LO +: 10] = last_word;
			end
			default: rd_hit = 1'b0;
		endcase
	end

	// Current contents merged under byte strobes
	always_comb begin
		unique case (wr_addr)
			SCL_OFF_CTRL: nw = merge({21'h00_0000, cfg}, wr_data, wr_strb);
			SCL_OFF_SLOT: nw = merge({8'h00, slot_dly}, wr_data, wr_strb);
			SCL_OFF_BIT: nw = merge({16'h0000, bit_cyc}, wr_data, wr_strb);
			SCL_OFF_PD: nw = merge({pd_on, pd_dly}, wr_data, wr_strb);
			SCL_OFF_SYNC: nw = merge({frst_cyc, judge_dly, sync_min}, wr_data, wr_strb);
			default: nw = merge({8'h00, blank_fix}, wr_data, wr_strb);
		endcase
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata <= 32'h0000_0000;
			rresp <= 2'h0;
		end else if (ce) begin
			if (arvalid && arready) begin
				rvalid <= 1'b1;
				rdata <= rd_mux;
				rresp <= rd_hit ? 2'h0 : 2'h2;
			end else if (rvalid && rready) begin
				rvalid <= 1'b0;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Sync detection

	logic tick;
	logic [7:0] det_cnt;
	logic [7:0] judge_t;
	logic [23:0] tref;
	logic timing;
	logic valid_seen;
	logic judge_ok;
	logic judge_bad;
	logic first_hit;
	logic [23:0] blank_len;
	logic [15:0] frst_left;
	logic [4:0] nbits;

	assign nbits = frame_bits(cfg.word_length_select, cfg.crc_sel);
	assign first_hit = ce && tick && st == ST_IDLE && sync_cmp;
	assign judge_ok = ce && tick && st == ST_JUDGE && judge_t == judge_dly
		&& det_cnt > sync_min; // see RQ2
	assign judge_bad = ce && tick && st == ST_JUDGE && judge_t == judge_dly
		&& det_cnt <= sync_min;
	// Variable blanking covers the own slot plus the whole frame
	assign blank_len = cfg.sync_blank_select
		? 24'(slot_dly + 24'(nbits) * 24'(bit_cyc)) : blank_fix; // see RQ4
	assign filter_reset = frst_left != 16'h0000;

	// Sample divider at half the clock rate
	always_ff @(posedge aclk) begin
		if (!aresetn) tick <= 1'b0;
		else if (ce) tick <= !tick;
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			st <= ST_IDLE;
			det_cnt <= 8'h00;
			judge_t <= 8'h00;
		end else if (ce && tick) begin
			unique case (st)
				ST_IDLE: if (sync_cmp) begin
					st <= ST_JUDGE;
					det_cnt <= 8'h01;
					judge_t <= 8'h00;
				end
				ST_JUDGE: if (judge_t == judge_dly) begin
					det_cnt <= 8'h00; // see RQ4
					st <= judge_ok ? ST_BLANK : ST_IDLE; // see RQ6
				end else begin
					judge_t <= judge_t + 8'h01;
					if (sync_cmp && det_cnt != 8'hFF)
						det_cnt <= det_cnt + 8'h01; // see RQ22
				end
				ST_BLANK: if (tref >= blank_len || !timing) st <= ST_IDLE;
			endcase
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tref <= 24'h00_0000;
			timing <= 1'b0;
			valid_seen <= 1'b0;
			sync_valid <= 1'b0;
			sync_cnt_total <= 8'h00;
		end else if (ce) begin
			sync_valid <= judge_ok; // see RQ3
			if (first_hit) begin
				tref <= 24'h00_0000; // see RQ7
				timing <= 1'b1;
				valid_seen <= 1'b0;
			end else if (judge_bad) begin
				timing <= 1'b0; // see RQ6
			end else if (timing) begin
				if (tref == 24'hFF_FFFF) timing <= 1'b0;
				else tref <= tref + 24'h00_0001;
			end
			if (judge_ok) begin
				valid_seen <= 1'b1; // see RQ3
				sync_cnt_total <= sync_cnt_total + 8'h01;
			end
		end
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) frst_left <= 16'h0000;
		else if (ce) begin
			if (judge_ok) frst_left <= frst_cyc; // see RQ5
			else if (filter_reset) frst_left <= frst_left - 16'h0001;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Frame build and Manchester transmitter

	logic tx_start;
	logic [9:0] word;
	logic [2:0] crc_v;
	logic [2:0] err;
	logic [14:0] next_frame;
	logic [14:0] shreg;
	logic [4:0] nleft;
	logic [15:0] hcnt;
	logic half;
	logic hend;
	logic pd_act;

	assign word = make_word(filt_data, cfg.kind, cfg.idx, cfg.word_length_select);
	assign crc_v = crc3(word, cfg.word_length_select);
	assign tx_start = ce && timing && valid_seen && tref == slot_dly
		&& !tx_busy; // see RQ9
	assign hend = hcnt == (bit_cyc[15:1] - 16'h0001);
	// Timed from the first sample, so a short delay may end before validation
	assign pd_act = cfg.pd_en && timing && {8'h00, pd_dly} <= tref
		&& tref < 24'({8'h00, pd_dly} + {8'h00, pd_on}); // see RQ8

	always_comb begin
		// Start bits are zero, so the word alone sets parity
		err = cfg.crc_sel ? {crc_v[0], crc_v[1], crc_v[2]}
			: {2'h0, ^word}; // see RQ12 RQ13
		next_frame = 15'h0000;
		if (cfg.word_length_select) next_frame[11:2] = word;
		else next_frame[9:2] = word[7:0]; // see RQ11
		next_frame = next_frame
			| (15'(err) << (cfg.word_length_select ? 4'd12 : 4'd10));
	end

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			tx_busy <= 1'b0;
			shreg <= 15'h0000;
			nleft <= 5'h00;
			hcnt <= 16'h0000;
			half <= 1'b0;
			last_word <= 10'h000;
		end else if (ce) begin
			if (tx_start) begin
				tx_busy <= 1'b1;
				shreg <= next_frame;
				nleft <= nbits;
				hcnt <= 16'h0000;
				half <= 1'b0;
				last_word <= word;
			end else if (tx_busy) begin
				if (hend) begin
					hcnt <= 16'h0000;
					half <= !half;
					if (half) begin
						shreg <= {1'b0, shreg[14:1]};
						nleft <= nleft - 5'h01;
						if (nleft == 5'h01) tx_busy <= 1'b0; // see RQ21
					end
				end else begin
					hcnt <= hcnt + 16'h0001;
				end
			end
		end
	end

	// Sink on means raised current: a zero rises at mid-bit
	always_ff @(posedge aclk) begin
		if (!aresetn) mod_sink <= 1'b0;
		else if (ce) mod_sink <= (tx_busy && (half ? !shreg[0] : shreg[0]))
			|| pd_act; // see RQ10
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	AST_JUDGE_OK: assert property (@(posedge aclk) disable iff (!aresetn) // see RQ2
		judge_ok |=> sync_valid && st == ST_BLANK && valid_seen)
		else $error("valid pulse not flagged");
	AST_JUDGE_BAD: assert property (@(posedge aclk) disable iff (!aresetn) // see RQ6
		judge_bad |=> st == ST_IDLE && !timing && !sync_valid)
		else $error("failed pulse did not rearm");
	AST_CNT_SAT: assert property (@(posedge aclk) disable iff (!aresetn) // see RQ22
		ce && st == ST_JUDGE && det_cnt == 8'hFF && judge_t != judge_dly
		|=> det_cnt == 8'hFF)
		else $error("detection counter wrapped");
	AST_FIRST_SAMPLE: assert property (@(posedge aclk) disable iff (!aresetn) // see RQ7
		first_hit |=> timing && tref == 24'h00_0000 && st == ST_JUDGE)
		else $error("timers not started at first sample");
	AST_FILT_RST: assert property (@(posedge aclk) disable iff (!aresetn) // see RQ5
		sync_valid && frst_cyc != 16'h0000 |-> filter_reset)
		else $error("filter reset missing after sync");
	AST_TX_SLOT: assert property (@(posedge aclk) disable iff (!aresetn) // see RQ9
		tx_start |=> tx_busy && nleft == nbits && shreg == $past(next_frame))
		else $error("frame not started at slot");
	AST_MID_EDGE: assert property (@(posedge aclk) disable iff (!aresetn) // see RQ10
		ce && tx_busy && !half && hend && !cfg.pd_en ##1 ce
		|=> mod_sink != $past(mod_sink))
		else $error("no mid-bit transition");
	AST_IDLE_LOW: assert property (@(posedge aclk) disable iff (!aresetn) // see RQ21
		ce && !tx_busy && !pd_act |=> !mod_sink)
		else $error("sink on while idle");
	AST_PARITY: assert property (@(posedge aclk) disable iff (!aresetn) // see RQ13
		tx_start && !cfg.crc_sel |-> ^next_frame == 1'b0)
		else $error("odd parity frame");
	AST_CRC_VEC: assert property (@(posedge aclk) disable iff (!aresetn) // see RQ15
		crc3(10'h000, 1'b1) == 3'h6 && crc3(10'h0CC, 1'b1) == 3'h3
		&& crc3(10'h3FF, 1'b1) == 3'h4)
		else $error("checksum reference mismatch");
	AST_PULLDOWN: assert property (@(posedge aclk) disable iff (!aresetn) // see RQ8
		ce && pd_act |=> mod_sink)
		else $error("pulldown sink not on");

	COV_VALID: cover property (@(posedge aclk) disable iff (!aresetn) judge_ok);
	COV_BAD: cover property (@(posedge aclk) disable iff (!aresetn) judge_bad);
	COV_FRAME_END: cover property (@(posedge aclk) disable iff (!aresetn)
		tx_busy ##1 !tx_busy);
	COV_CRC_FRAME: cover property (@(posedge aclk) disable iff (!aresetn)
		tx_start && cfg.crc_sel);
endmodule
`default_nettype wire

// ### tb/scl_master_model.sv
`timescale 1ns/1ps
`default_nettype none
module scl_master_model (
	// Clock and reset
	input wire logic aclk,
	input wire logic aresetn,
	// Bench commands
	input wire logic go,
	input wire logic [7:0] len,
	input wire logic [15:0] bit_cyc,
	// Link
	input wire logic mod_sink,
	output logic sync_cmp,
	output logic [15:0] rx_bits,
	output logic [4:0] rx_cnt
);
	int hold;
	int t;
	logic prev;
	// Positive supply step, length set by the bench to be short or long
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			hold <= 0;
		end else if (go) begin
			hold <= len;
		end else if (hold > 0) begin
			hold <= hold - 1;
		end
	end
	assign sync_cmp = hold > 0;
	// First rise is mid of the first start bit; sample a quarter bit later, inverted
	always_ff @(posedge aclk) begin
		prev <= mod_sink;
		if (!aresetn || go) begin
			t <= 0;
			rx_cnt <= '0;
			rx_bits <= '0;
		end else if (t == 0 && mod_sink && !prev && rx_cnt == 0) begin
			t <= bit_cyc / 4;
		end else if (t == 1) begin
			rx_bits[rx_cnt] <= !mod_sink;
			rx_cnt <= rx_cnt + 1;
			t <= bit_cyc;
		end else if (t > 1) begin
			t <= t - 1;
		end
	end
endmodule
`default_nettype wire

// ### tb/tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import scl_pkg::*;
	localparam int BITC = 40;
	localparam int SLOTC = 300;
	logic aclk, aresetn, ce, awvalid, wvalid, bready, arvalid, rready, go;
	logic awready, wready, bvalid, arready, rvalid;
	logic mod_sink, sync_valid, filter_reset, tx_busy, sync_cmp;
	logic [7:0] awaddr, araddr, len;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic [25:0] filt_data;
	logic [15:0] rx_bits, bit_cyc, lfsr;
	logic [4:0] rx_cnt;
	int num_errors = 0;
	int n_compared = 0;
	int cyc = 0;
	scl_link_tx #(.BLANK_FIX_CYC(200)) i_dut (.*);
	scl_master_model i_master (.*);
	initial begin
		aclk = 0;
		forever #2 aclk = ~aclk;
	end
	////////////////////////////////////////////////////////////////////////
	task automatic summarize;
		if (num_errors == 0 && n_compared > 0)
			$display("bench passed");
		else
			$display("bench failed");
		$finish;
	endtask
	// A hung handshake or frame ends the run here
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			num_errors++;
			summarize();
		end
	end
	task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
		n_compared++;
		if (got !== exp) begin
			num_errors++;
			$display("ERROR %s expected %h seen %h", nm, exp, got);
		end
	endtask
	function automatic logic [15:0] nxt(input logic [15:0] s);
		return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
	endfunction
	////////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		for (int n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (awvalid && awready)
				awvalid <= 1'b0;
			if (wvalid && wready)
				wvalid <= 1'b0;
			if (bvalid === 1'b1) begin
				bready <= 1'b0;
				chk("bresp", 32'(bresp), 32'(er));
				break;
			end
		end
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		for (int n = 0; n < 100; n++) begin
			@(posedge aclk);
			if (arvalid && arready)
				arvalid <= 1'b0;
			if (rvalid === 1'b1) begin
				rready <= 1'b0;
				chk("rdata", rdata, ed);
				chk("rresp", 32'(rresp), 32'(er));
				break;
			end
		end
	endtask
	////////////////////////////////////////////////////////////////////////
	// Reference frame: start bits, word LSB first, then C2..C0 or even parity
	function automatic logic [15:0] frame(input int v, input bit w10, input bit crc);
		logic [15:0] f;
		logic [2:0] c;
		int w;
		w = w10 ? 10 : 8;
		c = 3'b111;
		for (int i = 0; i < w + 3; i++)
			c = {c[1:0], (i < w) ? v[i] : 1'b0} ^ (c[2] ? 3'b011 : 3'b000);
		f = 16'(v & ((1 << w) - 1)) << 2;
		if (crc)
			f = f | (16'({c[0], c[1], c[2]}) << (w + 2));
		else
			f[w + 2] = ^f;
		return f;
	endfunction
	function automatic int accel(input logic [25:0] fd, input bit w10);
		int s, sh, lim;
		sh = w10 ? 12 : 14;
		lim = w10 ? 480 : 120;
		s = (int'($signed(fd)) >>> sh) + int'(fd[sh - 1]);
		return s > lim ? lim : (s < -lim ? -lim : s);
	endfunction
	function automatic int code(input int k, input bit w, input int x);
		case (k)
			1: return w ? 488 : 124;
			2: return w ? 487 : 123;
			3: return w ? 486 : 122;
			4: return w ? 500 : 125;
			5: return w ? x - 496 : x - 124;
			default: return w ? -497 - x : -125 - x;
		endcase
	endfunction
	task automatic pulse(input int l);
		@(posedge aclk);
		len <= 8'(l);
		go <= 1'b1;
		@(posedge aclk);
		go <= 1'b0;
	endtask
	// One sync, a stray pulse inside the blanking time, then the whole frame
	task automatic frm(input logic [31:0] ctl, input logic [25:0] fd, input int v);
		int n, sv, fr, nb;
		nb = 2 + (ctl[0] ? 10 : 8) + (ctl[1] ? 3 : 1);
		sv = 0;
		fr = 0;
		wr(SCL_OFF_CTRL, ctl, 2'd0);
		filt_data <= fd;
		pulse(30);
		for (n = 0; n < 2000 && tx_busy !== 1'b1; n++) begin
			@(posedge aclk);
			go <= (n == 100);
			sv += int'(sync_valid === 1'b1);
			fr += int'(filter_reset === 1'b1);
		end
		chk("slot", 32'(n >= SLOTC && n <= SLOTC + 5), 1);
		chk("valid syncs", sv, 1);
		chk("filter reset", fr, 20);
		for (n = 0; n < 1000 && tx_busy === 1'b1; n++)
			@(posedge aclk);
		chk("frame cycles", n, nb * BITC);
		repeat (BITC) @(posedge aclk);
		chk("idle", 32'(mod_sink), 0);
		chk("frame", 32'(rx_bits & 16'((1 << nb) - 1)), 32'(frame(v, ctl[0], ctl[1])));
	endtask
	////////////////////////////////////////////////////////////////////////
	initial begin
		int m, n, x, s;
		int dv[3] = '{0, 204, -1};
		logic [2:0] cr[3] = '{3'b011, 3'b110, 3'b001};
		{aresetn, awvalid, wvalid, bready, arvalid, rready, go} = '0;
		{awaddr, araddr, len, wdata, filt_data} = '0;
		ce = 1'b1;
		wstrb = 4'hF;
		bit_cyc = 16'(BITC);
		lfsr = 16'h8362;
		repeat (10) @(posedge aclk);
		aresetn <= 1'b1;
		rd(SCL_OFF_CTRL, 32'h0000_0001, 2'd0);
		rd(SCL_OFF_BIT, 32'h0000_07D0, 2'd0);
		rd(SCL_OFF_SYNC, 32'h03E8_7D3F, 2'd0);
		rd(8'h1C, 32'h0000_0000, 2'd2);
		wr(SCL_OFF_STAT, 32'h0000_0000, 2'd2);
		wr(SCL_OFF_SLOT, SLOTC, 2'd0);
		wr(SCL_OFF_BIT, BITC, 2'd0);
		wr(SCL_OFF_SYNC, 32'h0014_0A04, 2'd0);
		pulse(4);
		m = 0;
		repeat (60) @(posedge aclk) m += int'(sync_valid !== 1'b0 || tx_busy !== 1'b0);
		chk("short pulse", m, 0);
		for (int i = 0; i < 3; i++) begin
			frm(32'h0000_0003, 26'(dv[i] * 4096), dv[i]);
			chk("crc", 32'(rx_bits[14:12]), 32'(cr[i]));
		end
		for (int w = 0; w < 2; w++)
			for (int k = 1; k < 7; k++) begin
				lfsr = nxt(lfsr);
				x = int'(lfsr[1:0]);
				frm({21'd0, 4'(x), 3'(k), 1'b0, lfsr[3:2], 1'(w)}, '0, code(k, w, x));
			end
		for (int i = 0; i < 6; i++) begin
			lfsr = nxt(lfsr);
			s = $signed(lfsr) * (i + 1) * 64;
			frm(32'({{3{lfsr[6]}}, 2'b0, lfsr[5:4]}), 26'(s), accel(26'(s), lfsr[4]));
		end
		wr(SCL_OFF_PD, 32'h0014_000A, 2'd0);
		wr(SCL_OFF_CTRL, 32'h0000_0009, 2'd0);
		pulse(30);
		for (m = 0; m < 100 && mod_sink !== 1'b1; m++)
			@(posedge aclk);
		for (n = 0; n < 100 && mod_sink === 1'b1; n++)
			@(posedge aclk);
		chk("pulldown delay", 32'(m >= 10 && m <= 14), 1);
		chk("pulldown on", n, 20);
		summarize();
	end
endmodule
`default_nettype wire
